// File: design/mmc_mgmt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - select low lets the module answer two-wire management commands.
// - select high: no response and no acknowledge on the two-wire bus.
// - select input is biased high inside, so undriven means deselected.
// - reset input is pulled up inside; reset only when driven low.
// - complete reset starts only after reset pin low longer than minimum pulse.
// - complete reset returns every writable setting to its default.
// - reset assert time starts at the rising edge releasing the reset pin.
// - interrupt output is open collector, active low; host supplies pull-up.
// - interrupt released after status bit read as zero and flags read.
// - low-power pin pulled up inside, so undriven requests low power.
// - low-power state comes from pin plus takeover and request bits.
// - presence output tied low whenever the module is plugged in.
module mmc_mgmt_ctrl #(
    parameter logic [24:0] P_INIT_CYC = 25'(mmc_pkg::T_INIT_CYC)
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic        i_module_select_n,
    input  wire logic        i_module_reset_n,
    input  wire logic        i_low_power_pin,
    input  wire logic [7:0]  i_flag_events,
    output logic             o_sda,
    output logic             o_sda_oe,
    output logic             o_int_out,
    output logic             o_int_oe,
    output logic             o_low_power,
    output logic             o_presence_detect_n,
    output logic             o_select_bias_high,
    output logic             o_reset_pullup_en,
    output logic             o_lp_pullup_en,
    output logic             o_data_not_ready,
    output logic             o_in_reset
);
    mmc_link_if u_link ();
    logic [4:0]                  pin_s;
    logic                        scl_q, sda_q;
    logic                        sel_s, rst_s, lp_s, scl_s, sda_s;
    logic                        scl_rise, scl_fall, bus_start, bus_stop;

    mmc_pkg::mmc_phase_type      phase, next_phase;
    logic [7:0]                  low_cnt, next_low_cnt;
    logic [24:0]                 init_cnt, next_init_cnt;

    mmc_pkg::mmc_bus_state_type  st, next_st;
    logic [3:0]                  bit_cnt, next_bit_cnt;
    logic [7:0]                  ptr, next_ptr;
    logic [7:0]                  tx, next_tx;
    logic [7:0]                  rd_addr, next_rd_addr;
    logic                        rd_bit0, next_rd_bit0;
    logic                        sda_oe, next_sda_oe;
    logic                        rw, next_rw;
    logic                        first_w, next_first_w;
    logic                        rd_done, wr_en;

    logic [1:0]                  ctrl, next_ctrl;
    logic [7:0]                  flags, next_flags;
    logic [1:0]                  clr_wait, next_clr_wait; // bit 0 status, bit 1 flag field unread
    logic                        next_int_oe, next_low_power;

    // byte seen by the host at a given offset
    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic nr,
                                             input logic [7:0] f, input logic [1:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (a == mmc_pkg::STATUS_ADDR) begin
            v[mmc_pkg::NR_BIT] = nr;
        end else if (a == mmc_pkg::FLAG_ADDR) begin
            v = f;
        end else if (a == mmc_pkg::PWR_ADDR) begin
            v[1:0] = c;
        end
        return v;
    endfunction : read_byte

    // pins reset to their pulled levels: select high, reset high, low power high
    mmc_sync #(
        .W   (mmc_pkg::PIN_W),
        .RST (mmc_pkg::PIN_IDLE)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_async   ({i_sda, i_scl, i_low_power_pin, i_module_reset_n, i_module_select_n}),
        .o_sync    (pin_s)
    );

    // serial-clock domain shifter; words are read only while the clock is low
    assign u_link.scl = i_scl;
    assign u_link.sda = i_sda;
    mmc_link_shift u_shift (
        .i_nrst (i_nrst),
        .lnk    (u_link)
    );

    assign sel_s     = pin_s[mmc_pkg::PIN_SEL];
    assign rst_s     = pin_s[mmc_pkg::PIN_RST];
    assign lp_s      = pin_s[mmc_pkg::PIN_LP];
    assign scl_s     = pin_s[mmc_pkg::PIN_SCL];
    assign sda_s     = pin_s[mmc_pkg::PIN_SDA];
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
    assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    // reset pin filter and reset assert timing
    always_comb begin
        next_phase    = phase;
        next_init_cnt = init_cnt;
        next_low_cnt  = low_cnt;
        if (rst_s) begin
            next_low_cnt = 8'h00;
        end else if (low_cnt != mmc_pkg::RST_MIN_CNT) begin
            next_low_cnt = low_cnt + 8'h01;
        end
        unique case (phase)
            mmc_pkg::PH_RUN, mmc_pkg::PH_INIT: begin
                if (!rst_s && low_cnt == mmc_pkg::RST_MIN_CNT) begin
                    next_phase = mmc_pkg::PH_HELD;
                end else if (phase == mmc_pkg::PH_INIT) begin
                    next_init_cnt = init_cnt + 25'h1;
                    if (init_cnt == P_INIT_CYC - 25'h1) begin
                        next_phase = mmc_pkg::PH_RUN;
                    end
                end
            end
            mmc_pkg::PH_HELD: begin
                if (rst_s) begin
                    next_phase    = mmc_pkg::PH_INIT;
                    next_init_cnt = 25'h0;
                end
            end
            default: next_phase = mmc_pkg::PH_HELD;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            phase    <= mmc_pkg::PH_INIT;
            low_cnt  <= 8'h00;
            init_cnt <= 25'h0;
        end else begin
            phase    <= next_phase;
            low_cnt  <= next_low_cnt;
            init_cnt <= next_init_cnt;
        end
    end

    // two-wire slave; the core only samples the shifter after a clock fall,
    // which limits the serial clock to well below a tenth of the system clock
    always_comb begin
        next_st      = st;
        next_bit_cnt = bit_cnt;
        next_ptr     = ptr;
        next_tx      = tx;
        next_rd_addr = rd_addr;
        next_rd_bit0 = rd_bit0;
        next_sda_oe  = sda_oe;
        next_rw      = rw;
        next_first_w = first_w;
        rd_done      = 1'b0;
        wr_en        = 1'b0;
        if (sel_s || phase == mmc_pkg::PH_HELD) begin
            next_st     = mmc_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_st      = mmc_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
        end else if (bus_stop) begin
            next_st     = mmc_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            unique case (st)
                mmc_pkg::ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                mmc_pkg::ST_ADDR, mmc_pkg::ST_WDATA, mmc_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == mmc_pkg::BYTE_BITS) begin
                        if (st == mmc_pkg::ST_ADDR) begin
                            if (u_link.word[7:1] == mmc_pkg::DEV_ADDR) begin
                                next_st     = mmc_pkg::ST_ACK_ADDR;
                                next_sda_oe = 1'b1;
                                next_rw     = u_link.word[0];
                            end else begin
                                next_st = mmc_pkg::ST_IDLE;
                            end
                        end else if (st == mmc_pkg::ST_WDATA) begin
                            next_st      = mmc_pkg::ST_ACK_W;
                            next_sda_oe  = 1'b1;
                            next_first_w = 1'b0;
                            if (first_w) begin
                                next_ptr = u_link.word;
                            end else begin
                                wr_en    = 1'b1;
                                next_ptr = ptr + 8'h01;
                            end
                        end else begin
                            next_st     = mmc_pkg::ST_MACK;
                            next_sda_oe = 1'b0;
                            rd_done     = 1'b1;
                            next_ptr    = ptr + 8'h01;
                        end
                    end else if (scl_fall && st == mmc_pkg::ST_RDATA) begin
                        next_tx     = {tx[6:0], 1'b0};
                        next_sda_oe = ~tx[6];
                    end
                end
                mmc_pkg::ST_ACK_ADDR, mmc_pkg::ST_ACK_W, mmc_pkg::ST_MACK: begin
                    if (st == mmc_pkg::ST_MACK && scl_rise && sda_s) begin
                        next_st = mmc_pkg::ST_IDLE; // host ended the read
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_first_w = (st == mmc_pkg::ST_ACK_ADDR);
                        if (st == mmc_pkg::ST_ACK_W || !rw) begin
                            next_st     = mmc_pkg::ST_WDATA;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_st      = mmc_pkg::ST_RDATA;
                            next_tx      = read_byte(ptr, o_data_not_ready, flags, ctrl);
                            next_sda_oe  = ~next_tx[7];
                            next_rd_addr = ptr;
                            next_rd_bit0 = next_tx[mmc_pkg::NR_BIT];
                        end
                    end
                end
                default: begin
                    next_st     = mmc_pkg::ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st      <= mmc_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            ptr     <= 8'h00;
            tx      <= 8'h00;
            rd_addr <= 8'h00;
            rd_bit0 <= 1'b0;
            sda_oe  <= 1'b0;
            rw      <= 1'b0;
            first_w <= 1'b0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            st      <= next_st;
            bit_cnt <= next_bit_cnt;
            ptr     <= next_ptr;
            tx      <= next_tx;
            rd_addr <= next_rd_addr;
            rd_bit0 <= next_rd_bit0;
            sda_oe  <= next_sda_oe;
            rw      <= next_rw;
            first_w <= next_first_w;
            scl_q   <= scl_s;
            sda_q   <= sda_s;
        end
    end

    // settings and flags; a new event in the clearing cycle wins
    always_comb begin
        next_ctrl       = ctrl;
        next_flags      = flags | i_flag_events;
        next_clr_wait   = clr_wait;
        if (phase == mmc_pkg::PH_HELD) begin
            next_ctrl       = mmc_pkg::PWR_DEFAULT;
            next_flags      = 8'h00;
            next_clr_wait   = 2'h3;
        end else begin
            if (wr_en && ptr == mmc_pkg::PWR_ADDR) begin
                next_ctrl = u_link.word[1:0];
            end
            if (rd_done && rd_addr == mmc_pkg::FLAG_ADDR) begin
                next_flags       = i_flag_events;
                next_clr_wait[1] = 1'b0;
            end
            if (rd_done && rd_addr == mmc_pkg::STATUS_ADDR && !rd_bit0) begin
                next_clr_wait[0] = 1'b0;
            end
        end
        // release needs both clearing reads, not just the status byte
        next_int_oe    = (|clr_wait) | (|flags);
        next_low_power = ctrl[mmc_pkg::TAKEOVER_BIT] ? ctrl[mmc_pkg::LP_REQ_BIT] : lp_s;
    end

    // pull and tie outputs are constant flops; they model the module's own biasing
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl                <= mmc_pkg::PWR_DEFAULT;
            flags               <= 8'h00;
            clr_wait            <= 2'h3;
            o_int_oe            <= 1'b1;
            o_int_out           <= 1'b0;
            o_low_power         <= 1'b1;
            o_presence_detect_n <= 1'b0;
            o_select_bias_high  <= 1'b1;
            o_reset_pullup_en   <= 1'b1;
            o_lp_pullup_en      <= 1'b1;
            o_sda               <= 1'b0;
            o_data_not_ready    <= 1'b1;
            o_in_reset          <= 1'b0;
        end else begin
            ctrl                <= next_ctrl;
            flags               <= next_flags;
            clr_wait            <= next_clr_wait;
            o_int_oe            <= next_int_oe;
            o_int_out           <= 1'b0;
            o_low_power         <= next_low_power;
            o_presence_detect_n <= 1'b0;
            o_select_bias_high  <= 1'b1;
            o_reset_pullup_en   <= 1'b1;
            o_lp_pullup_en      <= 1'b1;
            o_sda               <= 1'b0;
            o_data_not_ready    <= (next_phase != mmc_pkg::PH_RUN);
            o_in_reset          <= (next_phase == mmc_pkg::PH_HELD);
        end
    end

    assign o_sda_oe = sda_oe;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_addr_ack_drive: assert property (st == mmc_pkg::ST_ACK_ADDR |-> o_sda_oe)
        else $error("address acknowledge not driven");
    a_desel_silent: assert property (sel_s |=> !o_sda_oe && st == mmc_pkg::ST_IDLE)
        else $error("deselected module drives the data line");
    a_pull_biasing: assert property (o_select_bias_high && o_reset_pullup_en)
        else $error("select or reset bias missing");
    a_reset_filter: assert property (phase == mmc_pkg::PH_RUN && !rst_s && low_cnt
        == mmc_pkg::RST_MIN_CNT |=> phase == mmc_pkg::PH_HELD)
        else $error("long reset pulse did not start a reset");
    a_short_pulse: assert property (phase == mmc_pkg::PH_RUN && low_cnt
        != mmc_pkg::RST_MIN_CNT |=> phase != mmc_pkg::PH_HELD)
        else $error("short reset pulse started a reset");
    a_reset_defaults: assert property (phase == mmc_pkg::PH_HELD |=> ctrl
        == mmc_pkg::PWR_DEFAULT && clr_wait == 2'h3)
        else $error("settings not restored to defaults");
    a_init_start: assert property (phase == mmc_pkg::PH_HELD && rst_s |=>
        phase == mmc_pkg::PH_INIT && init_cnt == 25'h0 ##1 init_cnt == 25'h1)
        else $error("assert time not started at reset release");
    a_int_open_drain: assert property (!o_int_out)
        else $error("interrupt line driven high");
    a_int_pending: assert property ((clr_wait != 2'h0 || flags != 8'h00) |=> o_int_oe)
        else $error("pending condition without interrupt");
    a_int_release: assert property (clr_wait == 2'h0 && flags == 8'h00 |=> !o_int_oe)
        else $error("interrupt held after clearing reads");
    a_lp_pin_path: assert property (!ctrl[mmc_pkg::TAKEOVER_BIT] |=>
        o_low_power == $past(lp_s))
        else $error("pin did not select low power");
    a_lp_sw_path: assert property (ctrl[mmc_pkg::TAKEOVER_BIT] |=>
        o_low_power == $past(ctrl[mmc_pkg::LP_REQ_BIT]))
        else $error("software request ignored under takeover");
    a_presence_low: assert property (!o_presence_detect_n && o_lp_pullup_en)
        else $error("presence not low or low-power pull missing");
endmodule : mmc_mgmt_ctrl
`default_nettype wire

// File: design/mmc_pkg.sv
`default_nettype none
package mmc_pkg;
    // system clock rate
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;

    // least low time on the reset pin before a complete reset starts
    localparam int             MIN_RESET_PULSE_NS = 10000;
    localparam int             RST_MIN_CYC = (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
    localparam int             RST_CNT_W   = 8;
    localparam logic [7:0]     RST_MIN_CNT = 8'(RST_MIN_CYC);

    // reset assert time, counted from the release of the reset pin
    localparam int             RESET_ASSERT_MS = 2000;
    localparam int             T_INIT_CYC      = RESET_ASSERT_MS * CLK_KHZ;
    localparam int             INIT_CNT_W      = 25;

    // two-wire slave address and byte map
    localparam logic [6:0]     DEV_ADDR    = 7'h50;
    localparam logic [7:0]     STATUS_ADDR = 8'h02;
    localparam logic [7:0]     FLAG_ADDR   = 8'h03;
    localparam logic [7:0]     PWR_ADDR    = 8'h5d;
    localparam int             NR_BIT      = 0;
    localparam int             TAKEOVER_BIT = 0;
    localparam int             LP_REQ_BIT   = 1;
    localparam logic [1:0]     PWR_DEFAULT  = 2'h0;
    localparam logic [3:0]     BYTE_BITS    = 4'h8;

    // synchronised pin vector: positions and idle (pulled) levels
    localparam int             PIN_W     = 5;
    localparam int             PIN_SEL   = 0;
    localparam int             PIN_RST   = 1;
    localparam int             PIN_LP    = 2;
    localparam int             PIN_SCL   = 3;
    localparam int             PIN_SDA   = 4;
    localparam logic [4:0]     PIN_IDLE  = 5'h1f;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ACK_ADDR = 7'h04,
        ST_WDATA    = 7'h08,
        ST_ACK_W    = 7'h10,
        ST_RDATA    = 7'h20,
        ST_MACK     = 7'h40
    } mmc_bus_state_type;

    typedef enum logic [2:0] {
        PH_RUN  = 3'h1,
        PH_HELD = 3'h2,
        PH_INIT = 3'h4
    } mmc_phase_type;
endpackage : mmc_pkg
`default_nettype wire

// File: design/mmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mmc_link_if;
    logic       scl;
    logic       sda;
    logic [7:0] word;
    modport shifter (input scl, input sda, output word);
    modport core    (output scl, output sda, input word);
endinterface : mmc_link_if
`default_nettype wire

// File: design/mmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mmc_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_nrst,
    input  wire logic [W-1:0]   i_async,
    output logic      [W-1:0]   o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    // reset to the pulled levels so undriven pins read idle
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta   <= RST;
            o_sync <= RST;
        end else begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule : mmc_sync
`default_nettype wire

// File: design/mmc_link_shift.sv
`timescale 1ns/1ps
`default_nettype none
module mmc_link_shift (
    input  wire logic        i_nrst,
    mmc_link_if.shifter      lnk
);
    logic [7:0] next_word;

    // serial data is taken on each rising edge of the serial clock
    always_comb begin
        next_word = {lnk.word[6:0], lnk.sda};
    end

    // word is stable for the whole low phase, when the core reads it
    always_ff @(posedge lnk.scl or negedge i_nrst) begin
        if (!i_nrst) begin
            lnk.word <= 8'h00;
        end else begin
            lnk.word <= next_word;
        end
    end
endmodule : mmc_link_shift
`default_nettype wire

// File: test/mmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// two-wire host controller; clock stands high between frames, data released means pulled high
module mmc_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_sda,
    output logic            o_rd_stb,
    output logic [7:0]      o_rd_byte
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_rd_stb = 1'b0;
        o_rd_byte = 8'h00;
    end
    // quarter bit of 5 sys cycles keeps the bus near 500 kHz, inside the sync margin
    task automatic hw(input int n);
        repeat (n) @(negedge i_clk);
    endtask : hw
    // start, or repeated start when called mid-frame
    task automatic start;
        o_sda = 1'b1;
        hw(5);
        o_scl = 1'b1;
        hw(5);
        o_sda = 1'b0;
        hw(5);
        o_scl = 1'b0;
        hw(5);
    endtask : start
    // data set while clock low, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        o_sda = b;
        hw(5);
        o_scl = 1'b1;
        hw(5);
        r = i_sda;
        hw(5);
        o_scl = 1'b0;
        hw(5);
    endtask : bitx
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic nak);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(last, nak);
    endtask : xfer
    task automatic stop;
        o_sda = 1'b0;
        hw(5);
        o_scl = 1'b1;
        hw(5);
        o_sda = 1'b1;
        hw(5);
    endtask : stop
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       n0, n1, n2;
        start();
        xfer({mmc_pkg::DEV_ADDR, 1'b0}, 1'b1, r, n0);
        xfer(p, 1'b1, r, n1);
        xfer(d, 1'b1, r, n2);
        stop();
        nak = n0 | n1 | n2;
    endtask : wr
    // pointer write, repeated start, one byte read and refused with a nack
    task automatic rd(input logic [7:0] p);
        logic [7:0] r;
        logic       n;
        start();
        xfer({mmc_pkg::DEV_ADDR, 1'b0}, 1'b1, r, n);
        xfer(p, 1'b1, r, n);
        start();
        xfer({mmc_pkg::DEV_ADDR, 1'b1}, 1'b1, r, n);
        xfer(8'hff, 1'b1, r, n);
        stop();
        o_rd_byte = r;
        o_rd_stb = 1'b1;
        hw(1);
        o_rd_stb = 1'b0;
    endtask : rd
endmodule : mmc_host_model
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int INIT = 50;
    logic        clk, nrst, sel_n, rst_n, lp, scl, host_sda, rd_stb, sda_oe, int_oe, low_pw;
    logic        pres_n, bias, rpu, lpu, dnr, in_rst, sda_q, int_q, nak;
    logic [7:0]  flags, rd_byte, fl;
    logic [31:0] seed = 32'hf7cf;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    logic [7:0]  expq[$];
    // open-drain lines resolved with the host pull-ups
    wire logic   sda = (sda_oe ? sda_q : 1'b1) & host_sda;
    wire logic   int_line = int_oe ? int_q : 1'b1;
    mmc_mgmt_ctrl #(.P_INIT_CYC(25'd50)) dut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda),
        .i_module_select_n(sel_n), .i_module_reset_n(rst_n), .i_low_power_pin(lp),
        .i_flag_events(flags), .o_sda(sda_q), .o_sda_oe(sda_oe), .o_int_out(int_q),
        .o_int_oe(int_oe), .o_low_power(low_pw), .o_presence_detect_n(pres_n),
        .o_select_bias_high(bias), .o_reset_pullup_en(rpu), .o_lp_pullup_en(lpu),
        .o_data_not_ready(dnr), .o_in_reset(in_rst));
    mmc_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda),
        .o_rd_stb(rd_stb), .o_rd_byte(rd_byte));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic cyc_w(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc_w
    // every byte the host reads is matched against the oldest note
    always @(posedge clk) if (rd_stb) check(rd_byte, expq.pop_front());
    // hang guard, well above the roughly eleven thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        nrst = 1'b0;
        sel_n = 1'b1;
        rst_n = 1'b1;
        lp = 1'b1;
        flags = 8'h00;
        cyc_w(16);
        check(pres_n, 8'h00);
        check({bias, rpu, lpu}, 8'h07);
        nrst = 1'b1;
        sel_n = 1'b0;
        cyc_w(INIT + 10);
        check(low_pw, 8'h01);
        check(int_line, 8'h00);
        expq.push_back(8'h00);
        host.rd(8'h02);
        cyc_w(4);
        check(int_oe, 8'h01);
        expq.push_back(8'h00);
        host.rd(8'h03);
        cyc_w(4);
        check(int_line, 8'h01);
        $display("interrupt release done");
        // every takeover and request combination against a random pin level
        for (int m = 0; m < 4; m++) begin
            seed = lfsr(seed);
            lp = seed[0];
            host.wr(8'h5d, 8'(m), nak);
            check(nak, 8'h00);
            expq.push_back(8'(m));
            host.rd(8'h5d);
            cyc_w(4);
            check(low_pw, m[0] ? m[1] : lp);
        end
        sel_n = 1'b1;
        cyc_w(4);
        host.wr(8'h5d, 8'h01, nak);
        check(nak, 8'h01);
        check(low_pw, 8'h01);
        sel_n = 1'b0;
        $display("power modes done");
        seed = lfsr(seed);
        fl = seed[7:0] | 8'h01;
        flags = fl;
        cyc_w(1);
        flags = 8'h00;
        cyc_w(3);
        check(int_oe, 8'h01);
        expq.push_back(8'h00);
        host.rd(8'h02);
        expq.push_back(fl);
        host.rd(8'h03);
        cyc_w(4);
        check(int_oe, 8'h00);
        $display("flag events done");
        lp = 1'b1;
        host.wr(8'h5d, 8'h01, nak);
        cyc_w(4);
        // a pulse below the minimum must be filtered out
        rst_n = 1'b0;
        cyc_w(40 + int'(seed[12:8]));
        rst_n = 1'b1;
        cyc_w(5);
        check(in_rst, 8'h00);
        check(low_pw, 8'h00);
        rst_n = 1'b0;
        cyc_w(110);
        check(in_rst, 8'h01);
        check(int_oe, 8'h01);
        rst_n = 1'b1;
        cyc_w(INIT - 5);
        check(dnr, 8'h01);
        cyc_w(15);
        check(dnr, 8'h00);
        check(low_pw, 8'h01);
        expq.push_back(8'h00);
        host.rd(8'h5d);
        cyc_w(4);
        $display("module reset done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
